// File: verilog/mssig_regs.vh
`ifndef MSSIG_REGS_VH
`define MSSIG_REGS_VH
// system clock rate
`define MSSIG_CLK_HZ          125000000
// blink toggle rates: a full cycle per period, so toggle twice as often
`define MSSIG_RATE_1HZ        1
`define MSSIG_RATE_2HZ        2
`define MSSIG_RATE_10HZ       10
// half periods in clock cycles
`define MSSIG_HALF_1HZ        (`MSSIG_CLK_HZ / (2 * `MSSIG_RATE_1HZ))
`define MSSIG_HALF_2HZ        (`MSSIG_CLK_HZ / (2 * `MSSIG_RATE_2HZ))
`define MSSIG_HALF_10HZ       (`MSSIG_CLK_HZ / (2 * `MSSIG_RATE_10HZ))
// connectable wake window and its period
`define MSSIG_WAKE_MS         11
`define MSSIG_PERIOD_MS       2500
`define MSSIG_BOOT_MS         500
`define MSSIG_WAKE_CYC        ((`MSSIG_CLK_HZ / 1000) * `MSSIG_WAKE_MS)
`define MSSIG_PERIOD_CYC      ((`MSSIG_CLK_HZ / 1000) * `MSSIG_PERIOD_MS)
`define MSSIG_BOOT_CYC        ((`MSSIG_CLK_HZ / 1000) * `MSSIG_BOOT_MS)
// green led modes
`define MSSIG_LED_OFF         3'h0
`define MSSIG_LED_10HZ        3'h1
`define MSSIG_LED_2HZ         3'h2
`define MSSIG_LED_1HZ         3'h3
`define MSSIG_LED_ON          3'h4
`endif

// File: verilog/mssig_blink.v
`timescale 1ns/1ps
// free running square wave: toggles every half_cyc cycles while enabled
module mssig_blink (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        run,
  input  wire [27:0] half_cyc,
  output reg         wave_reg
);
  reg [27:0] cnt_reg;

  // restart from low whenever not running, so each blink starts clean
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 28'h0000000;
      wave_reg <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_reg  <= 28'h0000000;
        wave_reg <= 1'b0;
      end else if (cnt_reg >= half_cyc - 28'h0000001) begin
        cnt_reg  <= 28'h0000000;
        wave_reg <= ~wave_reg;
      end else begin
        cnt_reg <= cnt_reg + 28'h0000001;
      end
    end
  end
endmodule // mssig_blink

// File: verilog/mssig_status.v
`timescale 1ns/1ps
`include "mssig_regs.vh"
// Summary of operation
// - status pin: 1Hz discoverable, 10Hz command, low connected
// - link state pin follows connection directly
// - green led rate follows operating mode
// - blue led shows radio transmit activity
// - host cts high sleeps when neither connected nor in command mode, low wakes
// - flow control on at power up
// - wake 11ms every 2.5s while in deep sleep
// - command mode refused until 500ms after boot
module mssig_status #(
  parameter PERIOD_CYC = `MSSIG_PERIOD_CYC,
  parameter WAKE_CYC   = `MSSIG_WAKE_CYC,
  parameter BOOT_CYC    = `MSSIG_BOOT_CYC,
  parameter HALF_1_CYC  = `MSSIG_HALF_1HZ,
  parameter HALF_2_CYC  = `MSSIG_HALF_2HZ,
  parameter HALF_10_CYC = `MSSIG_HALF_10HZ
) (
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  input  wire connected,
  input  wire discoverable,
  input  wire cmd_req,
  input  wire configuring,
  input  wire config_window,
  input  wire radio_tx,
  input  wire host_rts,
  input  wire uart_busy,
  input  wire flow_ctl_dis,
  output wire status_blink_pin,
  output wire link_state_pin,
  output reg  green_led,
  output wire blue_led,
  output wire dev_rts_n,
  output wire cmd_mode,
  output wire deep_sleep,
  output wire radio_on,
  output wire boot_done
);
  reg [31:0] boot_cnt_reg;
  reg [31:0] duty_cnt_reg;
  reg        conn_reg;
  reg        cmd_reg;
  reg        blue_reg;
  reg        rts_n_reg;
  reg        flow_en_reg;
  reg  [2:0] led_mode;
  reg  [2:0] op_state;
  reg        status_next;
  wire       w1;
  wire       w2;
  wire       w10;

  // operating states; connected outranks command outranks discoverable
  localparam ST_BOOT = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_DISC = 3'h2;
  localparam ST_CMD  = 3'h3;
  localparam ST_CONN = 3'h4;

  // one step of a counter, shared by the boot and duty timers
  function [31:0] count_up;
    input [31:0] value;
    begin
      count_up = value + 32'h00000001;
    end
  endfunction

  // blink half periods stay below 2^28 cycles, so the top bits are dropped
  function [27:0] to_half;
    input [31:0] cyc;
    begin
      to_half = cyc[27:0];
    end
  endfunction

  // green led rate from state; configuring outranks startup
  function [2:0] green_rate;
    input [2:0] state;
    input       cfg;
    input       cfg_win;
    begin
      if (state == ST_CONN)
        green_rate = `MSSIG_LED_ON;
      else if (cfg || state == ST_CMD)
        green_rate = `MSSIG_LED_10HZ;
      else if (cfg_win || state == ST_BOOT)
        green_rate = `MSSIG_LED_2HZ;
      else
        green_rate = `MSSIG_LED_1HZ;
    end
  endfunction

  // boot timer; saturates so the gate opens once and stays open
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_reg <= 32'h00000000;
    end else if (ce && boot_cnt_reg < BOOT_CYC) begin
      boot_cnt_reg <= count_up(boot_cnt_reg);
    end
  end
  assign boot_done = (boot_cnt_reg >= BOOT_CYC);

  // registered state; command mode only accepted after boot
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conn_reg    <= 1'b0;
      cmd_reg     <= 1'b0;
      blue_reg    <= 1'b0;
      flow_en_reg <= 1'b1;
      rts_n_reg   <= 1'b0;
    end else if (ce) begin
      conn_reg    <= connected;
      cmd_reg     <= cmd_req && boot_done;
      blue_reg    <= radio_tx;
      flow_en_reg <= ~flow_ctl_dis;
      // rts low means ready; with flow off never block the host
      rts_n_reg   <= flow_en_reg ? uart_busy : 1'b0;
    end
  end
  assign cmd_mode       = cmd_reg;
  assign link_state_pin = conn_reg;
  assign blue_led       = blue_reg;
  assign dev_rts_n      = rts_n_reg;

  // host rts drives our cts: high allows sleep, low wakes
  assign deep_sleep = host_rts && !conn_reg && !cmd_reg;

  // connectable duty cycle while asleep; radio on in first window
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_cnt_reg <= 32'h00000000;
    end else if (ce) begin
      if (!deep_sleep || duty_cnt_reg >= PERIOD_CYC - 1)
        duty_cnt_reg <= 32'h00000000;
      else
        duty_cnt_reg <= count_up(duty_cnt_reg);
    end
  end
  assign radio_on = !deep_sleep || (duty_cnt_reg < WAKE_CYC);

  // one blinker per rate, counted from the system clock
  // waves free run, so a state change picks up mid blink rather than restarting
  mssig_blink u_b1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .run      (1'b1),
    .half_cyc (to_half(HALF_1_CYC)),
    .wave_reg (w1)
  );
  mssig_blink u_b2 (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .run      (1'b1),
    .half_cyc (to_half(HALF_2_CYC)),
    .wave_reg (w2)
  );
  mssig_blink u_b10 (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .run      (1'b1),
    .half_cyc (to_half(HALF_10_CYC)),
    .wave_reg (w10)
  );

  // operating state: connected wins, then command, then boot, then discoverable
  always @* begin
    if (conn_reg)
      op_state = ST_CONN;
    else if (cmd_reg)
      op_state = ST_CMD;
    else if (!boot_done)
      op_state = ST_BOOT;
    else if (discoverable)
      op_state = ST_DISC;
    else
      op_state = ST_IDLE;
  end

  // status pin decode; low in every state with nothing to show
  always @* begin
    case (op_state)
      ST_CONN: status_next = 1'b0;
      ST_CMD:  status_next = w10;
      ST_DISC: status_next = w1;
      ST_BOOT: status_next = discoverable ? w1 : 1'b0;
      default: status_next = 1'b0;
    endcase
  end
  assign status_blink_pin = status_next;

  // green led mode priority
  always @* begin
    led_mode = green_rate(op_state, configuring, config_window);
  end

  // led registered so it never glitches on mode change
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      green_led <= 1'b0;
    end else if (ce) begin
      case (led_mode)
        `MSSIG_LED_ON:   green_led <= 1'b1;
        `MSSIG_LED_10HZ: green_led <= w10;
        `MSSIG_LED_2HZ:  green_led <= w2;
        `MSSIG_LED_1HZ:  green_led <= w1;
        default:         green_led <= 1'b0;
      endcase
    end
  end
endmodule // mssig_status

// File: test/mssig_status_properties.sv
`timescale 1ns/1ps
// ties each indicator and sleep output to its cause
module mssig_status_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic connected,
  input wire logic radio_tx,
  input wire logic host_rts,
  input wire logic flow_ctl_dis,
  input wire logic link_state_pin,
  input wire logic status_blink_pin,
  input wire logic green_led,
  input wire logic blue_led,
  input wire logic dev_rts_n,
  input wire logic cmd_mode,
  input wire logic deep_sleep,
  input wire logic radio_on,
  input wire logic boot_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // flow control off with the clock running, long enough for the enable path
  sequence flow_off_s;
    (ce && flow_ctl_dis) [*3];
  endsequence
  // a frozen cycle: nothing registered may move
  sequence frozen_s;
    !ce;
  endsequence
  link_follow_a: assert property (ce |=> link_state_pin == $past(connected)) else $error("link lag");
  blue_follow_a: assert property (ce |=> blue_led == $past(radio_tx)) else $error("blue lag");
  status_low_a: assert property (link_state_pin |-> !status_blink_pin) else $error("status busy");
  green_solid_a: assert property (ce && link_state_pin |=> green_led) else $error("green off");
  sleep_cond_a: assert property (deep_sleep == (host_rts && !link_state_pin && !cmd_mode)) else $error("sleep");
  cmd_hold_a: assert property (ce && !boot_done |=> !cmd_mode) else $error("early cmd");
  boot_stay_a: assert property (boot_done |=> boot_done) else $error("boot fell");
  rts_ready_a: assert property (flow_off_s |-> !dev_rts_n) else $error("rts held");
  awake_radio_a: assert property (!deep_sleep |-> radio_on) else $error("radio off");
  sleep_wake_a: assert property ($rose(deep_sleep) |-> radio_on) else $error("no wake slot");
  freeze_link_a: assert property (frozen_s |=> $stable(link_state_pin)) else $error("link moved");
  freeze_green_a: assert property (frozen_s |=> $stable(green_led)) else $error("green moved");
endmodule // mssig_status_properties
bind mssig_status mssig_status_properties chk_i (.*);

// File: test/mssig_host.sv
`timescale 1ns/1ps
// host mcu: its rts feeds our cts crosswise
module mssig_host (
  input  wire clk,
  input  wire rst_n,
  input  wire let_sleep,
  output reg  host_rts
);
  // low keeps the device awake, so that is the safe start
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) host_rts <= 1'b0;
    else host_rts <= let_sleep;
  end
endmodule // mssig_host

// File: test/mssig_status_test.sv
`timescale 1ns/1ps
module mssig_status_test;
  reg     clk, rst_n, conn, cmd, rtx, busy, fdis, nap, ce, disc, prev;
  wire    stat, link, grn, blu, rts_n, cmdm, slp, ron, boot, hrts;
  integer mismatches = 0, n_tests = 0, i, k;
  // short counts so boot and sleep periods fit the run
  mssig_status #(.PERIOD_CYC(200), .WAKE_CYC(20), .BOOT_CYC(50), .HALF_1_CYC(10), .HALF_2_CYC(5),
    .HALF_10_CYC(2)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .connected(conn), .discoverable(disc), .cmd_req(cmd), .configuring(1'b0), .config_window(1'b0),
    .radio_tx(rtx), .host_rts(hrts), .uart_busy(busy), .flow_ctl_dis(fdis), .status_blink_pin(stat),
    .link_state_pin(link), .green_led(grn), .blue_led(blu), .dev_rts_n(rts_n), .cmd_mode(cmdm),
    .deep_sleep(slp), .radio_on(ron), .boot_done(boot));
  mssig_host host (.clk(clk), .rst_n(rst_n), .let_sleep(nap), .host_rts(hrts));
  task chk(input logic seen, input logic want);
    n_tests++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch %0t bit", $time);
    end
  endtask
  task step(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // changes of status pin (sel 0) or green led (sel 1) over n cycles
  task toggles(input integer sel, input integer n);
    k = 0;
    prev = sel ? grn : stat;
    for (i = 0; i < n; i++) begin
      step(1);
      if ((sel ? grn : stat) !== prev) k = k + 1;
      prev = sel ? grn : stat;
    end
  endtask
  // rts follows busy only while flow control is on
  task t_flow;
    busy = 1'b1;
    step(3);
    chk(rts_n, 1'b1);
    fdis = 1'b1;
    step(3);
    chk(rts_n, 1'b0);
    fdis = 1'b0;
  endtask
  // command request refused until the boot count ends (6 edges already gone)
  task t_boot;
    cmd = 1'b1;
    step(42);
    chk(boot, 1'b0);
    chk(cmdm, 1'b0);
    step(4);
    chk(boot, 1'b1);
    chk(cmdm, 1'b1);
  endtask
  // blink rates: 1Hz discoverable, 10Hz command wins, low when idle
  task t_blink;
    disc = 1'b1;
    step(2);
    toggles(0, 40);
    chk(k == 4, 1'b1);
    toggles(1, 40);
    chk(k == 4, 1'b1);
    cmd = 1'b1;
    step(2);
    toggles(0, 40);
    chk(k == 20, 1'b1);
    toggles(1, 40);
    chk(k == 20, 1'b1);
    disc = 1'b0;
    cmd = 1'b0;
    step(2);
    toggles(0, 20);
    chk(k == 0, 1'b1);
  endtask
  // clock enable low freezes the link pin
  task t_freeze;
    ce = 1'b0;
    conn = 1'b1;
    step(2);
    chk(link, 1'b0);
    ce = 1'b1;
    step(2);
    chk(link, 1'b1);
    conn = 1'b0;
    step(2);
  endtask
  // connection overrides command mode
  task t_link;
    conn = 1'b1;
    rtx = 1'b1;
    step(2);
    chk(link, 1'b1);
    chk(stat, 1'b0);
    chk(grn, 1'b1);
    chk(blu, 1'b1);
    conn = 1'b0;
    cmd = 1'b0;
    step(2);
    chk(link, 1'b0);
  endtask
  // any full period asleep holds exactly one wake slice
  task t_sleep;
    nap = 1'b1;
    step(5);
    chk(slp, 1'b1);
    k = 0;
    for (i = 0; i < 200; i++) begin
      k = k + ron;
      step(1);
    end
    chk(k == 20, 1'b1);
    nap = 1'b0;
    step(3);
    chk(slp, 1'b0);
  endtask
  task print_verdict;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // free running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // run needs some 500 cycles; cut off far beyond
  initial begin
    #16000;
    mismatches++;
    print_verdict;
  end
  // reset, then the scenarios in turn
  initial begin
    {rst_n, conn, cmd, rtx, busy, fdis, nap, disc} = 8'h00;
    ce = 1'b1;
    step(3);
    rst_n = 1'b1;
    t_flow;
    t_boot;
    t_link;
    t_blink;
    t_freeze;
    t_sleep;
    print_verdict;
  end
endmodule // mssig_status_test
